// >>> hw/dbgbp_pkg.sv
// Function
// - debug port masters the internal system bus
// - shifted bits drive address, data, command
// - processor reset held while command asserted
// - separate commands hold whole system reset
// - interrupt handshake raised toward the processor
// - program DMA, release bus, then slave
// - DMA slave moves data only
// - breakpoint unit is bus slave
// - two independent breakpoint conditions
// - match address, data, control, DMA combination
// - fabric logic conditions counted as events
// - count occurrences, break at programmed count
// - break freezes processor or raises interrupt
// - frozen state blocks selected fabric clocks
// - bus reads remain possible while frozen
// - clearing freeze resumes where it stopped
// - processor reset restarts at address 0000h
// - single-step mode available at any time
// - only the four-pin test port used
// - code mapper high byte defaults differ
// - data and special mapper high byte defaults
// - high byte separates operand from opcode fetch
package dbgbp_pkg;
  localparam int CMD_W   = 48;
  localparam int OP_HI   = 47;
  localparam int OP_LO   = 44;
  localparam int ADDR_HI = 39;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam int DATA_LO = 0;
  localparam int BP_CH   = 2;
  localparam int CNT_W   = 16;

  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_BUS_WR    = 4'h1,
    OP_BUS_RD    = 4'h2,
    OP_CPU_RST   = 4'h3,
    OP_SYS_RST   = 4'h4,
    OP_INTR      = 4'h5,
    OP_DMA       = 4'h6,
    OP_DMA_DATA  = 4'h7,
    OP_STEP_MODE = 4'h8,
    OP_STEP      = 4'h9,
    OP_RESUME    = 4'ha,
    OP_CLK_BLOCK = 4'hb
  } dbgbp_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQ  = 4'b0010,
    ST_XFER = 4'b0100,
    ST_DONE = 4'b1000
  } dbgbp_st_t;

  // breakpoint window: addr[31:4], channel addr[3], register addr[2:0]
  localparam logic [27:0] BP_WIN     = 28'hffd_ff00;
  localparam logic [2:0]  BP_R_ADDR3 = 3'h3;
  localparam logic [2:0]  BP_R_DATA  = 3'h4;
  localparam logic [2:0]  BP_R_CTRL  = 3'h5;
  localparam logic [2:0]  BP_R_CNTLO = 3'h6;
  localparam logic [2:0]  BP_R_CNTHI = 3'h7;
  localparam int C_EN_ADDR = 0;
  localparam int C_EN_DATA = 1;
  localparam int C_EN_RD   = 2;
  localparam int C_EN_WR   = 3;
  localparam int C_EN_DMA  = 4;
  localparam int C_EN_FAB  = 5;
  localparam int C_FETCH   = 6;
  localparam int C_ACT_IRQ = 7;

  localparam logic [7:0] BOOT_CODE_OPERAND_HIGH_BYTE    = 8'h20;
  localparam logic [7:0] BOOT_CODE_OPCODE_HIGH_BYTE     = 8'h40;
  localparam logic [7:0] CODE_WINDOW1_OPERAND_HIGH_BYTE = 8'h28;
  localparam logic [7:0] CODE_WINDOW1_OPCODE_HIGH_BYTE  = 8'h48;
  localparam logic [7:0] CODE_WINDOW2_OPERAND_HIGH_BYTE = 8'h30;
  localparam logic [7:0] CODE_WINDOW2_OPCODE_HIGH_BYTE  = 8'h50;
  localparam logic [7:0] DATA_WINDOW0_HIGH_BYTE      = 8'h80;
  localparam logic [7:0] DATA_WINDOW1_HIGH_BYTE      = 8'h88;
  localparam logic [7:0] DATA_WINDOW2_HIGH_BYTE      = 8'h90;
  localparam logic [7:0] CONFIG_WINDOW_HIGH_BYTE     = 8'h98;
  localparam logic [7:0] DATA_WINDOW4_HIGH_BYTE      = 8'ha0;
  localparam logic [7:0] DATA_WINDOW5_HIGH_BYTE      = 8'ha8;
  localparam logic [7:0] SPECIAL_REG_LATCH_HIGH_BYTE = 8'he0;
  localparam logic [7:0] SPECIAL_REG_PIN_HIGH_BYTE   = 8'hc0;
endpackage

// >>> hw/dbgbp_bkpt.sv
`timescale 1ns/10ps
module dbgbp_bkpt (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [31:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic             sl_ack,
  output logic [7:0]       sl_rdata,
  input  wire logic [31:0] mon_addr,
  input  wire logic [7:0]  mon_data,
  input  wire logic        mon_rd,
  input  wire logic        mon_wr,
  input  wire logic        mon_dma,
  input  wire logic [dbgbp_pkg::BP_CH-1:0] fabric_evt,
  output logic             brk_freeze,
  output logic             brk_irq
);
  import dbgbp_pkg::*;
  typedef struct packed {
    logic [BP_CH-1:0][31:0]    adr;
    logic [BP_CH-1:0][7:0]     dat;
    logic [BP_CH-1:0][7:0]     ctl;
    logic [BP_CH-1:0][CNT_W-1:0] tgt;
    logic [BP_CH-1:0][CNT_W-1:0] cnt;
    logic [7:0] rdata;
    logic       ack;
    logic       frz;
    logic       irq;
  } dbgbp_bk_t;
  dbgbp_bk_t q, d;
  logic [BP_CH-1:0] hit;
  logic [BP_CH-1:0] brk;
  logic             sel;
  assign sel = (bus_addr[31:4] == BP_WIN) && (bus_wr || bus_rd) && !q.ack;
  genvar g;
  generate
    for (g = 0; g < BP_CH; g++) begin : g_ch
      logic [7:0] c;
      logic       op_fetch;
      logic       a_ok;
      assign c = q.ctl[g];
      // opcode fetch class from high byte
      assign op_fetch = mon_addr[31:24] == BOOT_CODE_OPCODE_HIGH_BYTE ||
                        mon_addr[31:24] == CODE_WINDOW1_OPCODE_HIGH_BYTE ||
                        mon_addr[31:24] == CODE_WINDOW2_OPCODE_HIGH_BYTE;
      assign a_ok = !c[C_EN_ADDR] || (c[C_FETCH] ? (op_fetch && mon_addr[23:0] == q.adr[g][23:0])
                                                 : mon_addr == q.adr[g]);
      assign hit[g] = |c[C_EN_FAB:C_EN_ADDR] && a_ok &&
                      (!c[C_EN_DATA] || mon_data == q.dat[g]) && (!c[C_EN_RD] || mon_rd) &&
                      (!c[C_EN_WR] || mon_wr) && (!c[C_EN_DMA] || mon_dma) &&
                      (!c[C_EN_FAB] || fabric_evt[g]) && (mon_rd || mon_wr || mon_dma || fabric_evt[g]);
      assign brk[g] = hit[g] && (q.cnt[g] + 16'h0001 >= q.tgt[g]);
    end
  endgenerate
  always_comb begin
    d = q;
    d.ack = sel;
    d.frz = 1'b0;
    d.irq = 1'b0;
    for (int i = 0; i < BP_CH; i++) begin
      if (sel && bus_wr && bus_addr[3] == i[0]) begin
        if (bus_addr[2:0] <= BP_R_ADDR3) d.adr[i][bus_addr[1:0]*8 +: 8] = bus_wdata;
        else if (bus_addr[2:0] == BP_R_DATA) d.dat[i] = bus_wdata;
        else if (bus_addr[2:0] == BP_R_CTRL) d.ctl[i] = bus_wdata;
        else if (bus_addr[2:0] == BP_R_CNTLO) d.tgt[i][7:0] = bus_wdata;
        else d.tgt[i][15:8] = bus_wdata;
      end
      if (brk[i]) d.cnt[i] = '0;
      else if (hit[i]) d.cnt[i] = q.cnt[i] + 16'h0001;
      if (brk[i] && q.ctl[i][C_ACT_IRQ]) d.irq = 1'b1;
      if (brk[i] && !q.ctl[i][C_ACT_IRQ]) d.frz = 1'b1;
    end
    if (sel && bus_addr[2:0] <= BP_R_ADDR3) d.rdata = q.adr[bus_addr[3]][bus_addr[1:0]*8 +: 8];
    else if (sel && bus_addr[2:0] == BP_R_DATA) d.rdata = q.dat[bus_addr[3]];
    else if (sel && bus_addr[2:0] == BP_R_CTRL) d.rdata = q.ctl[bus_addr[3]];
    else if (sel && bus_addr[2:0] == BP_R_CNTLO) d.rdata = q.cnt[bus_addr[3]][7:0];
    else if (sel) d.rdata = q.cnt[bus_addr[3]][15:8];
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) q <= '0;
    else q <= d;
  end
  assign sl_ack = q.ack;
  assign sl_rdata = q.rdata;
  assign brk_freeze = q.frz;
  assign brk_irq = q.irq;
  // the other channel may break in the same cycle, so only the chosen action is checked
  property p_brk_act;
    @(posedge clk) disable iff (!nrst) brk[0] |=> ($past(q.ctl[0][C_ACT_IRQ]) ? brk_irq : brk_freeze);
  endproperty
  a_brk_act: assert property (p_brk_act) else $error("break action differs from config");
endmodule

// >>> hw/dbgbp_top.sv
`timescale 1ns/10ps
module dbgbp_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             bus_req,
  input  wire logic        bus_gnt,
  output logic [31:0]      bus_addr,
  output logic [7:0]       bus_wdata,
  output logic             bus_wr,
  output logic             bus_rd,
  input  wire logic [7:0]  bus_rdata,
  input  wire logic        bus_ack,
  input  wire logic [31:0] mon_addr,
  input  wire logic [7:0]  mon_data,
  input  wire logic        mon_rd,
  input  wire logic        mon_wr,
  input  wire logic        dma_req,
  input  wire logic        dma_dir,
  input  wire logic [7:0]  dma_wdata,
  output logic             dma_ack,
  output logic [7:0]       dma_rdata,
  input  wire logic [dbgbp_pkg::BP_CH-1:0] fabric_evt,
  output logic             cpu_reset_hold,
  output logic             debug_force_system_reset,
  output logic             debug_force_system_reset_alt,
  output logic             debug_interrupt_handshake,
  input  wire logic        cpu_int_ack,
  output logic             cpu_freeze,
  output logic             cpu_bp_irq,
  output logic             cpu_step_mode,
  output logic             cpu_step,
  output logic [7:0]       fabric_clk_block
);
  import dbgbp_pkg::*;

  // link side, clocked by tck only
  typedef struct packed {
    logic [CMD_W-1:0] sh;
    logic [CMD_W-1:0] hold;
    logic             tog;
    logic             tms_p;
    logic             rtog_s1;
    logic             rtog_s2;
    logic             rtog_p;
    logic             tdo;
  } dbgbp_lnk_t;

  // system side, clocked by clk
  typedef struct packed {
    logic             tog_s1;
    logic             tog_s2;
    logic             tog_p;
    logic [CMD_W-1:0] cmd;
    dbgbp_st_t        st;
    logic             req;
    logic [31:0]      addr;
    logic [7:0]       wdata;
    logic             wr;
    logic             rd;
    logic [7:0]       rdat;
    logic [CMD_W-1:0] reply;
    logic             rtog;
    logic             cpu_rst;
    logic             sys_rst;
    logic             sys_rst_alt;
    logic             intr;
    logic             dma_mode;
    logic             dma_ack;
    logic [7:0]       dma_out;
    logic             freeze;
    logic             bp_irq;
    logic             step_mode;
    logic             step;
    logic [7:0]       clk_sel;
    logic [7:0]       blk;
  } dbgbp_core_t;

  dbgbp_lnk_t  ln_q;
  dbgbp_lnk_t  ln_d;
  dbgbp_core_t cr_q;
  dbgbp_core_t cr_d;

  logic        bp_ack;
  logic [7:0]  bp_rdata;
  logic        bp_freeze;
  logic        bp_irq;
  logic        new_cmd;
  logic        take;
  dbgbp_op_t   cur_op;
  logic        xfer_ack;
  logic [7:0]  status;

  // breakpoint slave snoops the master bus
  dbgbp_bkpt u_bkpt (
    .clk        (clk),
    .nrst       (nrst),
    .bus_addr   (cr_q.addr),
    .bus_wdata  (cr_q.wdata),
    .bus_wr     (cr_q.wr),
    .bus_rd     (cr_q.rd),
    .sl_ack     (bp_ack),
    .sl_rdata   (bp_rdata),
    .mon_addr   (mon_addr),
    .mon_data   (mon_data),
    .mon_rd     (mon_rd),
    .mon_wr     (mon_wr),
    .mon_dma    (dma_req && dma_ack),
    .fabric_evt (fabric_evt),
    .brk_freeze (bp_freeze),
    .brk_irq    (bp_irq)
  );

  // four-pin serial link on its own clock
  always_comb begin
    ln_d = ln_q;
    ln_d.rtog_s1 = cr_q.rtog;
    ln_d.rtog_s2 = ln_q.rtog_s1;
    ln_d.tms_p = tms;
    if (tms && !ln_q.tms_p) begin
      // update: hold stays put until the next update
      ln_d.hold = ln_q.sh;
      ln_d.tog = ~ln_q.tog;
    end else if (tms && ln_q.rtog_s2 != ln_q.rtog_p) begin
      // reply is stable once its toggle has been seen
      ln_d.sh = cr_q.reply;
      ln_d.rtog_p = ln_q.rtog_s2;
    end else if (!tms) begin
      ln_d.sh = {tdi, ln_q.sh[CMD_W-1:1]};
    end
    ln_d.tdo = ln_d.sh[0];
  end

  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      // idle tms is high: no false update at the first edge after reset
      ln_q <= '{tms_p: 1'b1, default: '0};
    end else begin
      ln_q <= ln_d;
    end
  end

  assign new_cmd = cr_q.tog_s2 != cr_q.tog_p;
  assign take = (cr_q.st == ST_IDLE) && new_cmd;
  assign cur_op = dbgbp_op_t'(ln_q.hold[OP_HI:OP_LO]);
  assign xfer_ack = bus_ack || bp_ack;
  assign status = {cr_q.freeze, cr_q.dma_mode, cr_q.cpu_rst, cr_q.sys_rst,
                   cr_q.sys_rst_alt, cr_q.intr, cr_q.step_mode, cr_q.st != ST_IDLE};

  always_comb begin
    cr_d = cr_q;
    cr_d.tog_s1 = ln_q.tog;
    cr_d.tog_s2 = cr_q.tog_s1;
    cr_d.step = 1'b0;
    cr_d.bp_irq = 1'b0;
    cr_d.dma_ack = 1'b0;
    if (cpu_int_ack) begin
      cr_d.intr = 1'b0;
    end
    case (cr_q.st)
      ST_IDLE: begin
        if (new_cmd) begin
          cr_d.tog_p = cr_q.tog_s2;
          cr_d.cmd = ln_q.hold;
          cr_d.st = ST_DONE;
          case (cur_op)
            OP_BUS_WR, OP_BUS_RD: begin
              // bus stays with the dma controller meanwhile
              if (!cr_q.dma_mode) begin
                cr_d.req = 1'b1;
                cr_d.addr = ln_q.hold[ADDR_HI:ADDR_LO];
                cr_d.wdata = ln_q.hold[DATA_HI:DATA_LO];
                cr_d.st = ST_REQ;
              end
            end
            OP_CPU_RST: begin
              cr_d.cpu_rst = ln_q.hold[0];
              // reset drops freeze, restart from zero
              if (ln_q.hold[0]) begin
                cr_d.freeze = 1'b0;
              end
            end
            OP_SYS_RST: begin
              cr_d.sys_rst = ln_q.hold[0];
              cr_d.sys_rst_alt = ln_q.hold[1];
            end
            OP_INTR: begin
              cr_d.intr = 1'b1;
            end
            OP_DMA: begin
              // release bus, serve as dma slave
              cr_d.dma_mode = ln_q.hold[0];
            end
            OP_DMA_DATA: begin
              cr_d.dma_out = ln_q.hold[DATA_HI:DATA_LO];
            end
            OP_STEP_MODE: begin
              // single step mode at any time
              cr_d.step_mode = ln_q.hold[0];
            end
            OP_STEP: begin
              cr_d.step = cr_q.step_mode;
            end
            OP_RESUME: begin
              // clear freeze, core resumes in place
              cr_d.freeze = 1'b0;
            end
            OP_CLK_BLOCK: begin
              cr_d.clk_sel = ln_q.hold[DATA_HI:DATA_LO];
            end
            default: begin
              cr_d.st = ST_DONE;
            end
          endcase
        end
      end
      ST_REQ: begin
        if (bus_gnt) begin
          cr_d.wr = cr_q.cmd[OP_HI:OP_LO] == OP_BUS_WR;
          cr_d.rd = cr_q.cmd[OP_HI:OP_LO] == OP_BUS_RD;
          cr_d.st = ST_XFER;
        end
      end
      ST_XFER: begin
        if (xfer_ack) begin
          if (cr_q.rd) begin
            cr_d.rdat = bp_ack ? bp_rdata : bus_rdata;
          end
          cr_d.wr = 1'b0;
          cr_d.rd = 1'b0;
          cr_d.req = 1'b0;
          cr_d.st = ST_DONE;
        end
      end
      ST_DONE: begin
        cr_d.reply = {status, cr_q.cmd[ADDR_HI:ADDR_LO], cr_q.rdat};
        cr_d.rtog = ~cr_q.rtog;
        cr_d.st = ST_IDLE;
      end
      default: begin
        cr_d.st = ST_IDLE;
      end
    endcase
    // data only, no address or control
    if (cr_q.dma_mode && dma_req && !cr_q.dma_ack) begin
      cr_d.dma_ack = 1'b1;
      if (!dma_dir) begin
        cr_d.rdat = dma_wdata;
      end
    end
    // break sets win over a clear
    if (bp_freeze) begin
      cr_d.freeze = 1'b1;
    end
    if (bp_irq) begin
      cr_d.bp_irq = 1'b1;
    end
    if (cpu_int_ack && cr_q.intr && !(take && cur_op == OP_INTR)) begin
      cr_d.intr = 1'b0;
    end
    // selected fabric clocks blocked when frozen
    cr_d.blk = cr_d.freeze ? cr_d.clk_sel : 8'h00;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cr_q <= '{st: ST_IDLE, default: '0};
    end else begin
      cr_q <= cr_d;
    end
  end

  assign tdo = ln_q.tdo;
  assign bus_req = cr_q.req;
  assign bus_addr = cr_q.addr;
  assign bus_wdata = cr_q.wdata;
  assign bus_wr = cr_q.wr;
  assign bus_rd = cr_q.rd;
  assign dma_ack = cr_q.dma_ack;
  assign dma_rdata = cr_q.dma_out;
  assign cpu_reset_hold = cr_q.cpu_rst;
  assign debug_force_system_reset = cr_q.sys_rst;
  assign debug_force_system_reset_alt = cr_q.sys_rst_alt;
  assign debug_interrupt_handshake = cr_q.intr;
  assign cpu_freeze = cr_q.freeze;
  assign cpu_bp_irq = cr_q.bp_irq;
  assign cpu_step_mode = cr_q.step_mode;
  assign cpu_step = cr_q.step;
  assign fabric_clk_block = cr_q.blk;

  sequence s_take(dbgbp_op_t o);
    take && cur_op == o;
  endsequence

  sequence s_xfer_end;
    cr_q.st == ST_XFER && xfer_ack ##1 cr_q.st == ST_DONE ##1 cr_q.st == ST_IDLE;
  endsequence

  property p_bus_own;
    @(posedge clk) disable iff (!nrst) (bus_rd || bus_wr) |-> bus_req && !cr_q.dma_mode;
  endproperty
  a_bus_own: assert property (p_bus_own) else $error("strobe without mastership");

  property p_addr;
    @(posedge clk) disable iff (!nrst) $rose(bus_rd || bus_wr) |-> bus_addr == cr_q.cmd[ADDR_HI:ADDR_LO];
  endproperty
  a_addr: assert property (p_addr) else $error("bus address not from command");

  property p_cpu_rst;
    @(posedge clk) disable iff (!nrst) s_take(OP_CPU_RST) |=> cpu_reset_hold == $past(ln_q.hold[0]);
  endproperty
  a_cpu_rst: assert property (p_cpu_rst) else $error("processor reset not following command");

  property p_sys_rst;
    @(posedge clk) disable iff (!nrst) s_take(OP_SYS_RST) |=> $stable(cpu_reset_hold) &&
      debug_force_system_reset == $past(ln_q.hold[0]);
  endproperty
  a_sys_rst: assert property (p_sys_rst) else $error("system reset not independent");

  property p_intr;
    @(posedge clk) disable iff (!nrst) s_take(OP_INTR) |=> debug_interrupt_handshake;
  endproperty
  a_intr: assert property (p_intr) else $error("handshake not raised");

  property p_dma;
    @(posedge clk) disable iff (!nrst) dma_ack |-> cr_q.dma_mode && !bus_req ##1 !dma_ack;
  endproperty
  a_dma: assert property (p_dma) else $error("dma acknowledge outside slave mode");

  property p_freeze;
    @(posedge clk) disable iff (!nrst) bp_freeze |=> cpu_freeze [*2];
  endproperty
  a_freeze: assert property (p_freeze) else $error("break did not freeze");

  property p_resume;
    @(posedge clk) disable iff (!nrst) take && cur_op == OP_RESUME && !bp_freeze |=> !cpu_freeze;
  endproperty
  a_resume: assert property (p_resume) else $error("freeze not cleared");

  property p_block;
    @(posedge clk) disable iff (!nrst) !cpu_freeze |-> fabric_clk_block == 8'h00;
  endproperty
  a_block: assert property (p_block) else $error("clocks blocked while running");

  property p_step;
    @(posedge clk) disable iff (!nrst) cpu_step |-> cpu_step_mode ##1 !cpu_step;
  endproperty
  a_step: assert property (p_step) else $error("step pulse wrong");

  property p_xfer;
    @(posedge clk) disable iff (!nrst) cr_q.st == ST_XFER && xfer_ack |-> s_xfer_end;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer did not complete");
endmodule

// >>> verification/dbgbp_host.sv
`timescale 1ns/10ps
module dbgbp_host (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  task automatic pulse();
    #3 tck = 1'b1;
    #3 tck = 1'b0;
  endtask

  task automatic xfer(input logic [47:0] w, output logic [47:0] r);
    #2.3;
    for (int i = 0; i < 48; i++) begin
      tms = 1'b0;
      tdi = w[i];
      r[i] = tdo;
      pulse();
    end
    tms = 1'b1;
    pulse();
    // released data line must not look valid
    tdi = ~tdi;
    // clock stops after the reply capture window
    repeat (100) pulse();
  endtask
endmodule

// >>> verification/jtag_debug_breakpoint_unit_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module jtag_debug_breakpoint_unit_test;
  import dbgbp_pkg::*;
  logic             clk = 1'b0;
  logic             nrst, tck, tms, tdi, tdo, bus_req, bus_gnt, bus_wr, bus_rd, bus_ack, req_seen;
  logic             mon_rd, mon_wr, dma_req, dma_dir, dma_ack, cpu_reset_hold, cpu_int_ack;
  logic             debug_force_system_reset, debug_force_system_reset_alt, debug_interrupt_handshake;
  logic             cpu_freeze, cpu_bp_irq, cpu_step_mode, cpu_step;
  logic [31:0]      bus_addr, mon_addr, wr_addr, a, r;
  logic [31:0]      seed = 32'h705f;
  logic [7:0]       bus_wdata, bus_rdata, mon_data, dma_wdata, dma_rdata, fabric_clk_block, wr_data, rd_data, d;
  logic [BP_CH-1:0] fabric_evt;
  logic [47:0]      rep;
  int               miscompares, tests_run, irq_n, step_n;

  dbgbp_top  dbgbp_top_inst (.*);
  dbgbp_host dbgbp_host_inst (.*);

  always #5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // arbiter and memory, random latency; window accesses ack themselves
  always @(posedge clk) begin
    #1;
    r = rnd();
    irq_n += cpu_bp_irq;
    step_n += cpu_step;
    if (bus_req)
      req_seen = 1'b1;
    bus_gnt = bus_req & (bus_gnt | r[0]);
    // new read byte first, so the byte recorded is the one that stands with the ack
    bus_rdata = r[15:8];
    if (bus_ack || !(bus_wr | bus_rd) || bus_addr[31:4] == BP_WIN || r[1]) begin
      bus_ack = 1'b0;
    end else begin
      bus_ack = 1'b1;
      rd_data = bus_rdata;
      wr_addr = bus_addr;
      wr_data = bus_wdata;
    end
  end

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic run(input logic [3:0] op, input logic [31:0] ad, input logic [7:0] dt);
    dbgbp_host_inst.xfer({op, 4'h0, ad, dt}, rep);
  endtask

  task automatic bpw(input logic ch, input logic [2:0] ra, input logic [7:0] v);
    run(OP_BUS_WR, {BP_WIN, ch, ra}, v);
  endtask

  task automatic ev(input logic [31:0] ma, input logic [BP_CH-1:0] fe);
    cyc(1);
    mon_addr = ma;
    mon_data = 8'(rnd());
    mon_rd = 1'b1;
    fabric_evt = fe;
    cyc(1);
    mon_rd = 1'b0;
    fabric_evt = '0;
    cyc(4);
  endtask

  task automatic dma(input logic dr, input logic [7:0] wd);
    logic got;
    got = 1'b0;
    cyc(1);
    dma_dir = dr;
    dma_wdata = wd;
    dma_req = 1'b1;
    for (int i = 0; i < 20 && !got; i++) begin
      cyc(1);
      got = (dma_ack === 1'b1);
    end
    dma_req = 1'b0;
    dma_wdata = ~wd;
    `CHK("dma_ack", 1'b1, got)
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    {nrst, bus_gnt, bus_ack, bus_rdata, mon_addr, mon_data, mon_rd, mon_wr} = '0;
    {dma_req, dma_dir, dma_wdata, fabric_evt, cpu_int_ack, req_seen} = '0;
    repeat (5) begin
      @(posedge clk);
      dbgbp_host_inst.pulse();
    end
    `CHK("rst_sys", 1'b0, debug_force_system_reset)
    nrst = 1'b1;
    cyc(4);
    repeat (4) begin
      a = rnd() & 32'h7fff_ffff;
      d = 8'(rnd());
      run(OP_BUS_WR, a, d);
      `CHK("wr_addr", a, wr_addr)
      `CHK("wr_data", d, wr_data)
      run(OP_BUS_RD, ~a, 8'h0);
      run(OP_NOP, 32'h0, 8'h0);
      `CHK("rd_data", rd_data, rep[7:0])
    end
    $display("test bus finished");
    run(OP_CPU_RST, 32'h0, 8'h1);
    `CHK("cpu_rst", 1'b1, cpu_reset_hold)
    `CHK("sys_rst", 1'b0, debug_force_system_reset)
    run(OP_SYS_RST, 32'h0, 8'h2);
    `CHK("sys_alt", 1'b1, debug_force_system_reset_alt)
    run(OP_SYS_RST, 32'h0, 8'h1);
    `CHK("sys_rst", 1'b1, debug_force_system_reset)
    `CHK("sys_alt", 1'b0, debug_force_system_reset_alt)
    `CHK("cpu_kept", 1'b1, cpu_reset_hold)
    run(OP_SYS_RST, 32'h0, 8'h0);
    run(OP_CPU_RST, 32'h0, 8'h0);
    `CHK("cpu_rel", 1'b0, cpu_reset_hold)
    run(OP_INTR, 32'h0, 8'h0);
    `CHK("intr", 1'b1, debug_interrupt_handshake)
    cyc(1);
    cpu_int_ack = 1'b1;
    cyc(1);
    cpu_int_ack = 1'b0;
    cyc(2);
    `CHK("intr_clr", 1'b0, debug_interrupt_handshake)
    run(OP_STEP, 32'h0, 8'h0);
    run(OP_STEP_MODE, 32'h0, 8'h1);
    `CHK("step_mode", 1'b1, cpu_step_mode)
    run(OP_STEP, 32'h0, 8'h0);
    `CHK("steps", 1, step_n)
    run(OP_STEP_MODE, 32'h0, 8'h0);
    $display("test control finished");
    bpw(1'b0, 3'h0, 8'h56);
    bpw(1'b0, 3'h1, 8'h34);
    bpw(1'b0, 3'h2, 8'h12);
    // address, read, opcode class, freeze
    bpw(1'b0, BP_R_CTRL, 8'h45);
    bpw(1'b0, BP_R_CNTLO, 8'h02);
    // fabric event, interrupt
    bpw(1'b1, BP_R_CTRL, 8'ha0);
    bpw(1'b1, BP_R_CNTLO, 8'h03);
    ev({BOOT_CODE_OPERAND_HIGH_BYTE, 24'h123456}, 2'b10);
    ev({CODE_WINDOW1_OPCODE_HIGH_BYTE, 24'h123456}, 2'b10);
    `CHK("frz_early", 1'b0, cpu_freeze)
    `CHK("irq_early", 0, irq_n)
    ev({CODE_WINDOW2_OPCODE_HIGH_BYTE, 24'h123456}, 2'b10);
    `CHK("frz", 1'b1, cpu_freeze)
    `CHK("irq", 1, irq_n)
    d = 8'(rnd());
    run(OP_CLK_BLOCK, 32'h0, d);
    `CHK("clk_blk", d, fabric_clk_block)
    run(OP_BUS_RD, 32'h100, 8'h0);
    run(OP_NOP, 32'h0, 8'h0);
    `CHK("frz_rd", rd_data, rep[7:0])
    `CHK("frz_st", 1'b1, rep[47])
    run(OP_RESUME, 32'h0, 8'h0);
    `CHK("resume", 1'b0, cpu_freeze)
    `CHK("clk_free", 8'h0, fabric_clk_block)
    $display("test breakpoint finished");
    run(OP_DMA, 32'h0, 8'h1);
    req_seen = 1'b0;
    run(OP_BUS_WR, 32'h200, 8'h5a);
    `CHK("no_bus", 1'b0, req_seen)
    d = 8'(rnd());
    run(OP_DMA_DATA, 32'h0, d);
    dma(1'b1, 8'h0);
    `CHK("dma_rd", d, dma_rdata)
    d = 8'(rnd());
    dma(1'b0, d);
    run(OP_NOP, 32'h0, 8'h0);
    run(OP_NOP, 32'h0, 8'h0);
    `CHK("dma_wr", d, rep[7:0])
    run(OP_DMA, 32'h0, 8'h0);
    $display("test dma finished");
    print_verdict();
  end

  // a run takes some 40 commands of about 1 us each
  initial begin
    #300000;
    miscompares++;
    print_verdict();
  end
endmodule
